// file: include/hiccup_pkg.sv
// Constants shared by the buck fault and hiccup manager
package hiccup_pkg;
  // Control clock rate
  localparam int CLK_HZ            = 20000000;
  // Deglitch and blanking times as printed
  localparam int OV_DEGLITCH_NS    = 5000;
  localparam int UV_DEGLITCH_NS    = 20000;
  localparam int BLANK_NS          = 150;
  localparam int CLK_NS            = 1000000000 / CLK_HZ;
  // Least times round up to whole cycles
  localparam int OV_DEGLITCH_CYC   = (OV_DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int UV_DEGLITCH_CYC   = (UV_DEGLITCH_NS + CLK_NS - 1) / CLK_NS;
  localparam int BLANK_CYC         = (BLANK_NS + CLK_NS - 1) / CLK_NS;
  // Over-current counting and hiccup wait length
  localparam int OC_EVENTS         = 3;
  localparam int OC_WINDOW         = 8;
  localparam int HICCUP_SS_COUNT   = 4;
  // Soft-start duration default, in clock cycles
  localparam int SS_CYC_DEFAULT    = 200000;
  // Switching period default, in clock cycles
  localparam int SW_PERIOD_DEFAULT = 66;
  localparam int SW_ON_DEFAULT     = 20;
  // Counter widths
  localparam int DG_W              = 10;
  localparam int SS_W              = 24;
  // Register map
  localparam logic [3:0] ADDR_STATUS = 4'h0;
  localparam logic [3:0] ADDR_MASK   = 4'h1;
  localparam logic [3:0] ADDR_STATE  = 4'h2;
  localparam logic [3:0] ADDR_SSLEN  = 4'h3;
  // Event bit positions
  localparam int EV_OV  = 0;
  localparam int EV_UV  = 1;
  localparam int EV_OC  = 2;
  localparam int EV_OT  = 3;
  localparam int EV_HIC = 4;
  localparam int EV_W   = 5;
  localparam logic [4:0] MASK_RESET = 5'h00;

  typedef enum logic [5:0] {
    ST_OFF     = 6'h01,
    ST_PREBIAS = 6'h02,
    ST_SS      = 6'h04,
    ST_RUN     = 6'h08,
    ST_OVHOLD  = 6'h10,
    ST_HICCUP  = 6'h20
  } state_t;
endpackage

// file: src/deglitch.sv
// Continuous-level deglitch filter with a cycle threshold
`timescale 1ns/10ps
module deglitch #(
  parameter int W   = 10,
  parameter int LEN = 100
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic sys_rst_in,
  // Level to filter and clear
  input  wire logic level_in,
  input  wire logic clear_in,
  // Filtered result
  output logic      hit_out
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         hit;
  } dg_t;
  dg_t r;
  dg_t next_r;

  always_comb begin
    next_r = r;
    if (clear_in || !level_in) begin
      next_r.cnt = '0;
      next_r.hit = 1'b0;
    end else if (r.cnt < W'(LEN)) begin
      next_r.cnt = r.cnt + 1'b1;
    end else begin
      // Hit only after the level stood longer than the whole length
      next_r.hit = 1'b1;
    end
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign hit_out = r.hit;
endmodule

// file: src/buck_fault_hiccup_manager.sv
// Fault supervision, hiccup restart and gate enable control
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/10ps
module buck_fault_hiccup_manager #(
  parameter int SS_CYC     = hiccup_pkg::SS_CYC_DEFAULT,
  parameter int SW_PERIOD  = hiccup_pkg::SW_PERIOD_DEFAULT,
  parameter int SW_ON      = hiccup_pkg::SW_ON_DEFAULT,
  parameter int SENSE_W    = 8,
  parameter int FIXED_LIM  = 8'h30
) (
  // Clock and reset
  input  wire logic               clk_in,
  input  wire logic               sys_rst_in,
  // Enable and supply lockouts
  input  wire logic               enable_in,
  input  wire logic               supply_ok_in,
  // Comparator results from the analog front end
  input  wire logic               fb_over_in,
  input  wire logic               fb_under_in,
  input  wire logic               fb_above_target_in,
  input  wire logic               hs_current_trip_in,
  input  wire logic               limit_clamp_in,
  input  wire logic               over_temp_in,
  // Low-side sense and programmed limit, digitised
  input  wire logic [SENSE_W-1:0] ls_sense_in,
  input  wire logic [SENSE_W-1:0] limit_ref_in,
  // Register port
  input  wire logic [3:0]         reg_addr_in,
  input  wire logic [31:0]        reg_wdata_in,
  input  wire logic               reg_wr_in,
  input  wire logic               reg_rd_in,
  output logic      [31:0]        reg_rdata_out,
  // Gate drives, power-good pin, soft-start flag and interrupt
  output logic                    hs_gate_out,
  output logic                    ls_gate_out,
  output logic                    power_good_output_out,
  output logic                    power_good_output_oe_out,
  output logic                    soft_start_active_out,
  output logic                    irq_out
);
  localparam int PW = $clog2(SW_PERIOD + 1);
  localparam int CW = hiccup_pkg::SS_W + 3;

  // Pin inputs pass two flip-flops
  logic [8:0] sync1;
  logic [8:0] sync2;
  logic [SENSE_W-1:0] sense1, sense2, lim1, lim2;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      sync1  <= '0;
      sync2  <= '0;
      sense1 <= '0;
      sense2 <= '0;
      lim1   <= '0;
      lim2   <= '0;
    end else begin
      sync1  <= {enable_in, supply_ok_in, fb_over_in, fb_under_in,
                 fb_above_target_in, hs_current_trip_in, limit_clamp_in,
                 over_temp_in, 1'b0};
      sync2  <= sync1;
      sense1 <= ls_sense_in;
      sense2 <= sense1;
      lim1   <= limit_ref_in;
      lim2   <= lim1;
    end
  end
  logic en_s, sup_s, ov_s, uv_s, tgt_s, hs_oc_s, clamp_s, ot_s;
  assign {en_s, sup_s, ov_s, uv_s, tgt_s, hs_oc_s, clamp_s, ot_s} =
    sync2[8:1];

  // Doubled sense against the selected limit
  function automatic logic over_limit(input logic [SENSE_W-1:0] s,
                                      input logic [SENSE_W-1:0] l);
    logic [SENSE_W:0] d;
    d = {s, 1'b0};
    return d > {1'b0, l};
  endfunction

  typedef struct packed {
    hiccup_pkg::state_t               st;
    logic [PW-1:0]                    phase;
    logic [hiccup_pkg::DG_W-1:0]      blank;
    logic                             sampled;
    logic                             ls_oc;
    logic                             oc_cut;
    logic [2:0]                       oc_cnt;
    logic [3:0]                       oc_win;
    logic [CW-1:0]                    tmr;
    logic                             after_hic;
    logic                             ov_latched;
    logic [hiccup_pkg::EV_W-1:0]      status;
    logic [hiccup_pkg::EV_W-1:0]      mask;
    logic [hiccup_pkg::SS_W-1:0]      ss_len;
    logic [31:0]                      rdata;
    logic                             hs;
    logic                             ls;
    logic                             pg_oe;
    logic                             irq;
    logic                             ss;
  } core_t;
  core_t r;
  core_t next_r;

  logic ov_hit, uv_hit, disabled;
  assign disabled = !(en_s && sup_s);

  // Deglitch timers
  deglitch #(.W(hiccup_pkg::DG_W), .LEN(hiccup_pkg::OV_DEGLITCH_CYC)) u_ov (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .level_in   (ov_s),
    .clear_in   (disabled),
    .hit_out    (ov_hit)
  );
  deglitch #(.W(hiccup_pkg::DG_W), .LEN(hiccup_pkg::UV_DEGLITCH_CYC)) u_uv (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .level_in   (uv_s),
    .clear_in   (disabled || r.st == hiccup_pkg::ST_SS),
    .hit_out    (uv_hit)
  );

  always_comb begin
    logic new_cycle, on_time, oc_event, ls_trip, hs_ok, hic_go, switching;
    logic [SENSE_W-1:0] lim;
    logic [hiccup_pkg::EV_W-1:0] ev;
    next_r = r;
    ev = '0;
    hic_go = 1'b0;
    // Idle states take no samples, so a hiccup wait is never restarted
    switching = (r.st == hiccup_pkg::ST_SS) || (r.st == hiccup_pkg::ST_RUN);
    new_cycle = (r.phase == PW'(SW_PERIOD - 1));
    on_time = (r.phase < PW'(SW_ON));
    next_r.phase = new_cycle ? '0 : r.phase + 1'b1;
    // Fixed threshold when the reference is clamped
    lim = clamp_s ? SENSE_W'(FIXED_LIM) : lim2;
    // Blanking counter starts with each off-time
    if (r.phase == PW'(SW_ON)) begin
      next_r.blank = '0;
      next_r.sampled = 1'b0;
    end else if (r.blank < hiccup_pkg::DG_W'(hiccup_pkg::BLANK_CYC)) begin
      next_r.blank = r.blank + 1'b1;
    end
    ls_trip = 1'b0;
    // One sample per switching cycle after blanking
    if (!on_time && !r.sampled &&
        r.blank >= hiccup_pkg::DG_W'(hiccup_pkg::BLANK_CYC)) begin
      next_r.sampled = 1'b1;
      ls_trip = switching && over_limit(sense2, lim);
      next_r.ls_oc = ls_trip;
    end
    if (new_cycle) begin
      next_r.oc_cut = 1'b0;
    end
    if (on_time && r.hs && hs_oc_s) begin
      next_r.oc_cut = 1'b1;
    end
    oc_event = ls_trip || (on_time && r.hs && hs_oc_s && !r.oc_cut);
    // Events counted within the window from the first one, clean cycles between allowed
    if (new_cycle) begin
      next_r.oc_win = (r.oc_cnt == '0) ? '0 : r.oc_win + 1'b1;
    end
    if (r.oc_win >= 4'(hiccup_pkg::OC_WINDOW)) begin
      next_r.oc_cnt = '0;
      next_r.oc_win = '0;
    end
    if (oc_event) begin
      ev[hiccup_pkg::EV_OC] = 1'b1;
      next_r.oc_cnt = r.oc_cnt + 1'b1;
      if (r.oc_cnt == 3'(hiccup_pkg::OC_EVENTS - 1)) begin
        hic_go = 1'b1;
      end
    end
    // High side waits for a clean cycle after a low-side trip
    // After a high-side cut the next pulse may start, so every tripped cycle counts an event
    hs_ok = !r.ls_oc && !r.oc_cut && !(r.hs && hs_oc_s);
    next_r.hs = 1'b0;
    next_r.ls = 1'b0;
    next_r.pg_oe = 1'b1;
    unique case (r.st)
      hiccup_pkg::ST_OFF: begin
        if (!disabled) begin
          next_r.st = tgt_s ? hiccup_pkg::ST_PREBIAS
                            : hiccup_pkg::ST_SS;
          next_r.tmr = '0;
        end
      end
      hiccup_pkg::ST_PREBIAS: begin
        if (!tgt_s) begin
          next_r.st = hiccup_pkg::ST_SS;
          next_r.tmr = '0;
        end
      end
      hiccup_pkg::ST_SS, hiccup_pkg::ST_RUN: begin
        next_r.hs = on_time && hs_ok;
        next_r.ls = !on_time;
        next_r.tmr = r.tmr + 1'b1;
        if (r.st == hiccup_pkg::ST_SS &&
            r.tmr >= CW'(r.ss_len) - 1'b1) begin
          next_r.st = hiccup_pkg::ST_RUN;
          next_r.after_hic = 1'b0;
        end
        // Only over-current counts during a soft-start that follows a hiccup
        if (r.st == hiccup_pkg::ST_RUN || !r.after_hic) begin
          if (ov_hit && r.st == hiccup_pkg::ST_RUN) begin
            ev[hiccup_pkg::EV_OV] = 1'b1;
            next_r.ov_latched = 1'b1;
            next_r.st = hiccup_pkg::ST_OVHOLD;
            next_r.hs = 1'b0;
            next_r.ls = 1'b1;
          end
          if (uv_hit) begin
            ev[hiccup_pkg::EV_UV] = 1'b1;
            hic_go = 1'b1;
          end
          if (ot_s) begin
            ev[hiccup_pkg::EV_OT] = 1'b1;
            hic_go = 1'b1;
          end
        end
        if (r.st == hiccup_pkg::ST_RUN && !uv_s && !ov_s && !r.ls_oc) begin
          next_r.pg_oe = 1'b0;
        end
      end
      hiccup_pkg::ST_OVHOLD: begin
        next_r.ls = 1'b1;
        if (uv_s) begin
          hic_go = 1'b1;
        end
      end
      hiccup_pkg::ST_HICCUP: begin
        next_r.tmr = r.tmr + 1'b1;
        // Over-temperature must clear before the restart
        if (r.tmr >= CW'(r.ss_len) * CW'(hiccup_pkg::HICCUP_SS_COUNT) - 1'b1
            && !ot_s) begin
          next_r.st = hiccup_pkg::ST_SS;
          next_r.after_hic = 1'b1;
          next_r.tmr = '0;
        end
      end
      default: next_r.st = hiccup_pkg::ST_OFF;
    endcase
    if (hic_go) begin
      ev[hiccup_pkg::EV_HIC] = 1'b1;
      next_r.st = hiccup_pkg::ST_HICCUP;
      next_r.tmr = '0;
      next_r.hs = 1'b0;
      next_r.ls = 1'b0;
      next_r.pg_oe = 1'b1;
      next_r.oc_cnt = '0;
      next_r.oc_win = '0;
      next_r.ls_oc = 1'b0;
    end
    // Disable drops everything and clears the state timer and over-current counters
    if (disabled) begin
      next_r.st = hiccup_pkg::ST_OFF;
      next_r.tmr = '0;
      next_r.oc_cnt = '0;
      next_r.oc_win = '0;
      next_r.ls_oc = 1'b0;
      next_r.after_hic = 1'b0;
      next_r.ov_latched = 1'b0;
      next_r.hs = 1'b0;
      next_r.ls = 1'b0;
      next_r.pg_oe = 1'b1;
    end
    if (next_r.st != hiccup_pkg::ST_OVHOLD) begin
      next_r.ov_latched = 1'b0;
    end
    next_r.ss = (next_r.st == hiccup_pkg::ST_SS);
    // Register port: read of status clears it, new events still win
    next_r.rdata = '0;
    if (reg_rd_in) begin
      unique case (reg_addr_in)
        hiccup_pkg::ADDR_STATUS: next_r.rdata = 32'(r.status);
        hiccup_pkg::ADDR_MASK:   next_r.rdata = 32'(r.mask);
        hiccup_pkg::ADDR_STATE:  next_r.rdata = 32'({r.ov_latched, r.st});
        hiccup_pkg::ADDR_SSLEN:  next_r.rdata = 32'(r.ss_len);
        default:                 next_r.rdata = '0;
      endcase
    end
    next_r.status = ((reg_rd_in && reg_addr_in == hiccup_pkg::ADDR_STATUS)
                     ? '0 : r.status) | ev;
    if (reg_wr_in) begin
      if (reg_addr_in == hiccup_pkg::ADDR_MASK) begin
        next_r.mask = reg_wdata_in[hiccup_pkg::EV_W-1:0];
      end
      if (reg_addr_in == hiccup_pkg::ADDR_SSLEN &&
          reg_wdata_in[hiccup_pkg::SS_W-1:0] != '0) begin
        next_r.ss_len = reg_wdata_in[hiccup_pkg::SS_W-1:0];
      end
    end
    next_r.irq = |(next_r.status & next_r.mask);
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      r        <= '0;
      r.st     <= hiccup_pkg::ST_OFF;
      r.mask   <= hiccup_pkg::MASK_RESET;
      r.ss_len <= hiccup_pkg::SS_W'(SS_CYC);
      r.pg_oe  <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  // Outputs straight from flip-flops; the power-good pin level is tied low
  assign reg_rdata_out            = r.rdata;
  assign hs_gate_out              = r.hs;
  assign ls_gate_out              = r.ls;
  assign power_good_output_out    = 1'b0;
  assign power_good_output_oe_out = r.pg_oe;
  assign soft_start_active_out    = r.ss;
  assign irq_out                  = r.irq;
endmodule

// file: sim/hiccup_assertions.sv
// Concurrent checks on the fault and hiccup manager ports
`timescale 1ns/10ps
module hiccup_assertions (
  // Clock and reset
  input wire logic clk_in,
  input wire logic sys_rst_in,
  // Watched inputs
  input wire logic enable_in,
  input wire logic fb_over_in,
  input wire logic fb_under_in,
  input wire logic hs_current_trip_in,
  input wire logic over_temp_in,
  // Watched outputs
  input wire logic hs_gate_out,
  input wire logic ls_gate_out,
  input wire logic power_good_output_out,
  input wire logic power_good_output_oe_out,
  input wire logic soft_start_active_out
);
  logic [9:0] ov_cnt;
  logic [9:0] uv_cnt;
  logic       all_off;
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  assign all_off = !hs_gate_out && !ls_gate_out && power_good_output_oe_out;
  // Run lengths outside soft-start; saturate so a long fault never wraps
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      ov_cnt <= 10'h000;
      uv_cnt <= 10'h000;
    end else begin
      if (!fb_over_in || !enable_in || soft_start_active_out) begin
        ov_cnt <= 10'h000;
      end else if (ov_cnt != 10'h3FF) begin
        ov_cnt <= ov_cnt + 10'h001;
      end
      if (!fb_under_in || !enable_in || soft_start_active_out) begin
        uv_cnt <= 10'h000;
      end else if (uv_cnt != 10'h3FF) begin
        uv_cnt <= uv_cnt + 10'h001;
      end
    end
  end
  // Low side held on with power-good low, outside soft-start
  sequence ov_hold_s;
    (ls_gate_out && power_good_output_oe_out && !soft_start_active_out)[*8];
  endsequence
  sequence under_seen_s;
    fb_under_in[*4];
  endsequence
  pg_pin_low_a: assert property (power_good_output_out == 1'b0)
    else $error("power-good pin driven high");
  pg_softstart_a: assert property (
    soft_start_active_out |-> power_good_output_oe_out)
    else $error("power-good released in soft-start");
  disable_off_a: assert property ((!enable_in)[*5] |-> all_off)
    else $error("drives active while disabled");
  temp_off_a: assert property (
    (over_temp_in && !soft_start_active_out)[*6] |-> all_off)
    else $error("drives active in over-temperature");
  hs_trip_a: assert property (
    hs_current_trip_in |-> ##[0:4] !hs_gate_out)
    else $error("high-side pulse not ended on trip");
  ov_act_a: assert property (
    ov_cnt == 10'd110 |-> !hs_gate_out && ls_gate_out
      && power_good_output_oe_out)
    else $error("over-voltage response missing");
  uv_act_a: assert property (uv_cnt == 10'd420 |-> all_off)
    else $error("under-voltage hiccup missing");
  ov_exit_a: assert property (
    ov_hold_s ##1 under_seen_s |-> ##[0:6] !ls_gate_out)
    else $error("over-voltage hold not left");
endmodule
bind buck_fault_hiccup_manager hiccup_assertions chk_u (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .enable_in(enable_in),
  .fb_over_in(fb_over_in), .fb_under_in(fb_under_in),
  .hs_current_trip_in(hs_current_trip_in), .over_temp_in(over_temp_in),
  .hs_gate_out(hs_gate_out), .ls_gate_out(ls_gate_out),
  .power_good_output_out(power_good_output_out),
  .power_good_output_oe_out(power_good_output_oe_out),
  .soft_start_active_out(soft_start_active_out));

// file: sim/tb.sv
// Self-checking bench for the fault and hiccup manager
`timescale 1ns/10ps
module tb;
  localparam int SS = 64;
  logic        clk_in, sys_rst_in, enable_in, supply_ok_in;
  logic        fb_over_in, fb_under_in, fb_above_target_in;
  logic        hs_current_trip_in, limit_clamp_in, over_temp_in;
  logic [7:0]  ls_sense_in, limit_ref_in;
  logic [3:0]  reg_addr_in;
  logic [31:0] reg_wdata_in, reg_rdata_out, d;
  logic        reg_wr_in, reg_rd_in, hs_gate_out, ls_gate_out, irq_out;
  logic        power_good_output_out, power_good_output_oe_out;
  logic        soft_start_active_out;
  int          errors, n_tests, n, m;
  buck_fault_hiccup_manager #(.SS_CYC(SS), .SW_PERIOD(16), .SW_ON(5)) dut_u (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .enable_in(enable_in),
    .supply_ok_in(supply_ok_in), .fb_over_in(fb_over_in),
    .fb_under_in(fb_under_in), .fb_above_target_in(fb_above_target_in),
    .hs_current_trip_in(hs_current_trip_in),
    .limit_clamp_in(limit_clamp_in), .over_temp_in(over_temp_in),
    .ls_sense_in(ls_sense_in), .limit_ref_in(limit_ref_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .hs_gate_out(hs_gate_out),
    .ls_gate_out(ls_gate_out),
    .power_good_output_out(power_good_output_out),
    .power_good_output_oe_out(power_good_output_oe_out),
    .soft_start_active_out(soft_start_active_out), .irq_out(irq_out));
  task automatic print_verdict();
    if (errors == 0 && n_tests > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_tests++;
    if (g !== e) begin
      errors++;
      $display("[FAIL] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rng(input string nm, input int v, lo, hi);
    chk(nm, 32'h1, {31'h0, v >= lo && v <= hi});
  endtask
  task automatic gates(input string nm, input logic [2:0] e);
    chk(nm, {29'h0, e},
        {29'h0, hs_gate_out, ls_gate_out, power_good_output_oe_out});
  endtask
  task automatic tick(input int k);
    repeat (k) @(posedge clk_in);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_wdata_in <= v;
    reg_wr_in <= 1'b1;
    @(posedge clk_in);
    reg_wr_in <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    @(posedge clk_in);
    reg_addr_in <= a;
    reg_rd_in <= 1'b1;
    @(posedge clk_in);
    reg_rd_in <= 1'b0;
    #1 v = reg_rdata_out;
  endtask
  task automatic wait_ss(input logic lvl, input int mx);
    n = 0;
    while (soft_start_active_out !== lvl && n < mx) begin
      @(posedge clk_in);
      n++;
    end
  endtask
  // Three quiet cycles mark hiccup, since one gap may be a dead time
  task automatic wait_off(input int mx);
    int r;
    r = 0;
    n = 0;
    while (r < 3 && n < mx) begin
      @(posedge clk_in);
      n++;
      r = (hs_gate_out === 1'b0 && ls_gate_out === 1'b0) ? r + 1 : 0;
    end
  endtask
  task automatic to_run();
    wait_ss(1'b1, 300);
    wait_ss(1'b0, SS + 8);
    tick(4);
    m = 0;
    repeat (32) @(posedge clk_in) m += hs_gate_out;
    rng("switching", m, 6, 12);
  endtask
  task automatic t_reset();
    gates("reset", 3'b001);
    chk("pg pin", 0, power_good_output_out);
    rd(hiccup_pkg::ADDR_MASK, d);
    chk("mask", {27'h0, hiccup_pkg::MASK_RESET}, d);
    rd(hiccup_pkg::ADDR_SSLEN, d);
    chk("sslen", SS, d);
    wr(4'hF, 32'hFFFFFFFF);
    rd(4'hF, d);
    chk("unmapped", 0, d);
    rd(hiccup_pkg::ADDR_STATE, d);
    chk("state off", hiccup_pkg::ST_OFF, d);
  endtask
  task automatic t_start();
    @(posedge clk_in);
    fb_under_in <= 1'b1;
    enable_in <= 1'b1;
    supply_ok_in <= 1'b1;
    wait_ss(1'b1, 10);
    rng("ss begin", n, 1, 8);
    tick(SS / 2);
    chk("pg ss", 1, power_good_output_oe_out);
    wait_ss(1'b0, SS);
    rng("ss len", n + SS / 2, SS - 4, SS + 4);
    fb_under_in <= 1'b0;
    tick(6);
    chk("pg run", 0, power_good_output_oe_out);
    rd(hiccup_pkg::ADDR_STATE, d);
    chk("state run", hiccup_pkg::ST_RUN, d);
  endtask
  task automatic t_ov();
    int k;
    @(posedge clk_in);
    fb_over_in <= 1'b1;
    tick(110);
    gates("ov gates", 3'b011);
    rd(hiccup_pkg::ADDR_STATE, d);
    chk("ov state", 32'h50, d);
    @(posedge clk_in);
    fb_over_in <= 1'b0;
    fb_under_in <= 1'b1;
    wait_off(12);
    k = n;
    rng("ov exit", n, 3, 10);
    chk("hiccup pg", 1, power_good_output_oe_out);
    wait_ss(1'b1, 300);
    rng("hiccup wait", k + n, 4 * SS + 1, 4 * SS + 12);
    rd(hiccup_pkg::ADDR_STATUS, d);
    chk("ov status", 32'h11, d);
    wait_ss(1'b0, SS + 8);
    rng("ss after hiccup", n, SS - 8, SS + 2);
    wait_off(450);
    rng("uv delay", n, 400, 420);
    fb_under_in <= 1'b0;
    to_run();
  endtask
  task automatic t_oc();
    wr(hiccup_pkg::ADDR_MASK, 32'h0);
    rd(hiccup_pkg::ADDR_STATUS, d);
    @(posedge clk_in);
    limit_ref_in <= 8'h3F;
    ls_sense_in <= 8'h1F;
    tick(48);
    @(posedge clk_in);
    limit_clamp_in <= 1'b1;
    limit_ref_in <= 8'hFF;
    ls_sense_in <= 8'h18;
    tick(48);
    rd(hiccup_pkg::ADDR_STATUS, d);
    chk("no trip", 0, d);
    @(posedge clk_in);
    ls_sense_in <= 8'h19;
    tick(24);
    m = 0;
    repeat (40) @(posedge clk_in) m += hs_gate_out;
    chk("hs blocked", 0, m);
    chk("irq masked", 0, irq_out);
    wr(hiccup_pkg::ADDR_MASK, 32'h1F);
    tick(2);
    chk("irq set", 1, irq_out);
    rd(hiccup_pkg::ADDR_STATUS, d);
    chk("oc status", 32'h14, d & 32'h14);
    tick(2);
    chk("irq clear", 0, irq_out);
    ls_sense_in <= 8'h00;
    limit_clamp_in <= 1'b0;
    to_run();
  endtask
  task automatic t_hs();
    @(posedge clk_in);
    hs_current_trip_in <= 1'b1;
    wait_off(80);
    rng("hs trip hiccup", n, 3, 70);
    tick(70);
    rd(hiccup_pkg::ADDR_STATE, d);
    chk("hs hiccup", hiccup_pkg::ST_HICCUP, d);
    hs_current_trip_in <= 1'b0;
    to_run();
  endtask
  task automatic t_ot();
    @(posedge clk_in);
    over_temp_in <= 1'b1;
    tick(6);
    gates("ot gates", 3'b001);
    tick(400);
    chk("ot hold", 0, soft_start_active_out);
    @(posedge clk_in);
    over_temp_in <= 1'b0;
    wait_ss(1'b1, 10);
    rng("ot restart", n, 1, 8);
    wait_ss(1'b0, SS + 8);
  endtask
  task automatic t_pre();
    @(posedge clk_in);
    enable_in <= 1'b0;
    tick(6);
    gates("disabled", 3'b001);
    @(posedge clk_in);
    fb_above_target_in <= 1'b1;
    enable_in <= 1'b1;
    tick(40);
    chk("pre", 4'b0001, {soft_start_active_out, hs_gate_out, ls_gate_out,
        power_good_output_oe_out});
    rd(hiccup_pkg::ADDR_STATE, d);
    chk("pre state", hiccup_pkg::ST_PREBIAS, d);
    @(posedge clk_in);
    fb_above_target_in <= 1'b0;
    wait_ss(1'b1, 10);
    rng("pre release", n, 1, 8);
  endtask
  initial begin
    clk_in = 1'b0;
    forever #25 clk_in = ~clk_in;
  end
  // Whole run is some 2700 cycles
  initial begin
    repeat (12000) @(posedge clk_in);
    errors++;
    print_verdict();
  end
  initial begin
    errors = 0;
    n_tests = 0;
    {sys_rst_in, enable_in, supply_ok_in, fb_over_in, fb_under_in} = 5'h10;
    {fb_above_target_in, hs_current_trip_in, limit_clamp_in} = 3'h0;
    {over_temp_in, reg_wr_in, reg_rd_in} = 3'h0;
    {ls_sense_in, limit_ref_in, reg_addr_in} = 20'h00000;
    reg_wdata_in = 32'h0;
    tick(16);
    sys_rst_in <= 1'b0;
    t_reset();
    t_start();
    t_ov();
    t_oc();
    t_hs();
    t_ot();
    t_pre();
    print_verdict();
  end
endmodule
